// *** verilog/hbpg_pkg.sv ***
// package for the half-bridge pwm gate sequencer: register map, fields, states
// assumes a 32-bit apb slave with byte addresses and cycle-based timing
package hbpg_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CCP = 8'h04;
  localparam logic [7:0] A_TARGET = 8'h08;
  localparam logic [7:0] A_CURRENT = 8'h0c;
  localparam logic [7:0] A_PREDIS = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_MEAS = 8'h18;
  // control field positions
  localparam int F_AGC = 0;
  localparam int F_GEN_EN = 2;
  localparam int F_DEEP = 3;
  localparam int F_BANK = 4;
  localparam int F_MODE = 5;
  localparam int F_PWM_EN = 7;
  // bridge_mode_select encodings
  localparam logic [1:0] MODE_HS_PWM = 2'h1;
  localparam logic [1:0] MODE_LS_PWM = 2'h2;
  // gate_adapt_select encodings
  localparam logic [1:0] AGC_PLAIN = 2'h0;
  localparam logic [1:0] AGC_PDIS = 2'h1;
  // gate current codes: five bits, 00000 lowest to 11111 highest
  localparam int CW = 5;
  localparam logic [4:0] CODE_MIN = 5'h00;
  localparam logic [4:0] CODE_MAX = 5'h1f;
  // reset values
  localparam logic [31:0] RST_CTRL = 32'h0000_0020;
  localparam logic [7:0] RST_CCP = 8'h10;
  localparam logic [7:0] RST_TGT = 8'h08;
  localparam logic [7:0] RST_PTIME = 8'h04;
  // regulation windows, in pwm cycles
  localparam logic [3:0] REG_MATCH_N = 4'h8;
  localparam int REG_WIN = 8;
  localparam logic [3:0] REG_FLIPS = 4'h3;
  // synchroniser length, in pclk cycles
  localparam int SYNC_STAGES = 3;
  // gate sequencing states, gray along the adaptive path from S_OFF to S_DIS
  typedef enum logic [2:0] {
    S_OFF = 3'h0,
    S_WAIT_ON = 3'h1,
    S_PRECHG = 3'h3,
    S_CHG = 3'h2,
    S_SYM = 3'h6,
    S_PREDIS = 3'h7,
    S_DIS = 3'h5
  } hbpg_state_type;
endpackage

// *** verilog/hbpg_sync.sv ***
// pin synchroniser: four flops per bit, a change counts once stages two and three agree
// assumes asynchronous pins and a single pclk domain
`timescale 1ns/1ps
module hbpg_sync
  import hbpg_pkg::*;
#(
  parameter int W = 3
)(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins and synchronised levels
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lv;
  } hbpg_sync_type;
  hbpg_sync_type s_r, s_nxt;

  // first stage only feeds the second, so metastability never reaches a decision
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.s1 = pin;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    for (int i = 0; i < W; i++)
    begin
      if (s_r.s2[i] == s_r.s3[i])
      begin
        s_nxt.lv[i] = s_r.s3[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign level = s_r.lv;

  // a pin held high reaches the output four edges after it is first sampled high
  property p_sync_delay;
    @(posedge pclk) disable iff (!presetn)
    ($rose(pin[0]) ##1 pin[0] [*4]) |-> level[0];
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync latency wrong");
endmodule

// *** verilog/hbpg_core.sv ***
// half-bridge pwm gate sequencer with apb register file
// assumes pins are asynchronous to pclk; gate outputs feed analog drivers
// Operation
// - high-side generator pwm sequences like low-side load on inverted pwm
// - delays and edge times are applied and measured on the active mosfet
// - one delay regulated flag, meaningful only in adaptive modes 10 and 11
// - flag sets after eight consecutive cycles with delays matching targets
// - flag sets after three error sign flips within the last eight cycles
// - deep adaptation splits precharge and predischarge into two current steps
// - leave deep adaptation when unregulated and precharge time indivisible
// - modes 00 and 01 stop regulation but still report measured delays
// - mode 00 sequences as adaptive without precharge and predischarge
// - mode 01 adds predischarge using the initial predischarge code
// - very low or high duty disables active free-wheeling
// - short off-time: pwm mosfet active, load assumed, delayed one fw ccp
// - high duty holds the opposite mosfet off
// - short on-time: pwm mosfet active, load assumed, delayed one ccp
// - delays still measured at very low or very high duty, but not used for adaptation
// - gate currents chosen from 32 steps
// - bank select 0 routes to active charge and discharge registers
// - bank select 1 routes to the free-wheel current register
// - current codes are five bits, 00000 lowest, 11111 highest
// - external pwm is synchronised to pclk with a fixed delay
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module hbpg_core
  import hbpg_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins from the bridge and the pwm source
  input wire logic pwm_pin,
  input wire logic gen_sense_pin,
  input wire logic bridge_switched_pin,
  // gate drive
  output logic hs_on,
  output logic ls_on,
  output logic [4:0] hs_code,
  output logic [4:0] ls_code
);
  typedef struct packed {
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic [7:0] ctrl;
    logic [7:0] ccp_act;
    logic [7:0] ccp_fw;
    logic [7:0] tgt_on;
    logic [7:0] tgt_off;
    logic [4:0] act_chg;
    logic [4:0] act_dis;
    logic [4:0] fw_chg;
    logic [4:0] fw_dis;
    logic [4:0] pdis_init;
    logic [7:0] pdis_time;
    logic [7:0] pchg_time;
    hbpg_state_type st;
    logic [7:0] tmr;
    logic pwm_d;
    logic sw_d;
    logic gen;
    logic low_duty;
    logic high_duty;
    logic [7:0] on_cnt;
    logic [7:0] off_cnt;
    logic [7:0] dly_cnt;
    logic [7:0] meas_on;
    logic [7:0] meas_off;
    logic got_on;
    logic got_off;
    logic [4:0] pre_code;
    logic [4:0] pdis_code;
    logic [3:0] match_cnt;
    logic [REG_WIN-1:0] sign_hist;
    logic regulated;
    logic deep;
    logic [3:0] miss_cnt;
    logic fw_on;
    logic hs;
    logic ls;
    logic [4:0] hcode;
    logic [4:0] lcode;
  } hbpg_core_type;
  hbpg_core_type s_r, s_nxt;

  logic [2:0] pins_s;
  logic pwm_s, gen_s, sw_s;
  logic eff_pwm, hs_pwm, act_is_hs, special, adaptive, wr, rd;
  logic [4:0] act_code;

  // pins are asynchronous: one synchroniser for all three
  hbpg_sync #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin({bridge_switched_pin, gen_sense_pin, pwm_pin}),
    .level(pins_s)
  );
  assign pwm_s = pins_s[0];
  assign gen_s = pins_s[1];
  assign sw_s = pins_s[2];

  // saturating step of a five-bit code
  function automatic logic [4:0] step_code(input logic [4:0] c, input logic up);
    logic [4:0] r;
    r = c;
    if (up && c != CODE_MAX)
    begin
      r = c + 5'h01;
    end
    else if (!up && c != CODE_MIN)
    begin
      r = c - 5'h01;
    end
    return r;
  endfunction

  // 8-bit saturating increment
  function automatic logic [7:0] inc8(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction

  // count sign changes between neighbours of the history window
  function automatic logic [3:0] flips(input logic [REG_WIN-1:0] h);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 1; i < REG_WIN; i++)
    begin
      n = n + {3'h0, h[i] ^ h[i-1]};
    end
    return n;
  endfunction

  // mode decode and role swap
  assign hs_pwm = (s_r.ctrl[F_MODE +: 2] == MODE_HS_PWM);
  assign adaptive = s_r.ctrl[F_AGC + 1];
  assign special = s_r.low_duty | s_r.high_duty;
  assign eff_pwm = s_r.gen ? ~pwm_s : pwm_s;
  assign act_is_hs = hs_pwm ^ s_r.gen;
  assign wr = psel & penable & pwrite & s_r.rdy;
  assign rd = psel & penable & ~pwrite & ~s_r.rdy;

  always_comb
  begin
    s_nxt = s_r;
    act_code = s_r.act_chg;
    // apb: one wait state, decode on the access phase, writes land with pready
    s_nxt.rdy = psel & penable & ~s_r.rdy;
    s_nxt.err = 1'b0;
    if (psel & penable & ~s_r.rdy)
    begin
      s_nxt.err = !(paddr inside {A_CTRL, A_CCP, A_TARGET, A_CURRENT, A_PREDIS,
                                  A_STATUS, A_MEAS}) || (paddr[1:0] != 2'h0);
    end
    if (rd)
    begin
      case (paddr)
        A_CTRL: s_nxt.rdata = {24'h0, s_r.ctrl};
        A_CCP: s_nxt.rdata = {16'h0, s_r.ccp_fw, s_r.ccp_act};
        A_TARGET: s_nxt.rdata = {16'h0, s_r.tgt_off, s_r.tgt_on};
        A_CURRENT: s_nxt.rdata = s_r.ctrl[F_BANK] ? {22'h0, s_r.fw_dis, s_r.fw_chg}
                                                  : {22'h0, s_r.act_dis, s_r.act_chg};
        A_PREDIS: s_nxt.rdata = {8'h0, s_r.pchg_time, s_r.pdis_time, 3'h0, s_r.pdis_init};
        A_STATUS: s_nxt.rdata = {19'h0, s_r.pre_code, 3'h0, s_r.gen, s_r.high_duty,
                                 s_r.low_duty, s_r.deep, s_r.regulated};
        A_MEAS: s_nxt.rdata = {16'h0, s_r.meas_off, s_r.meas_on};
        default: s_nxt.rdata = 32'h0;
      endcase
    end
    if (wr)
    begin
      case (paddr)
        A_CTRL: s_nxt.ctrl = pwdata[7:0];
        A_CCP:
        begin
          s_nxt.ccp_act = pwdata[7:0];
          s_nxt.ccp_fw = pwdata[15:8];
        end
        A_TARGET:
        begin
          s_nxt.tgt_on = pwdata[7:0];
          s_nxt.tgt_off = pwdata[15:8];
        end
        A_CURRENT:
        begin
          if (s_r.ctrl[F_BANK])
          begin
            s_nxt.fw_chg = pwdata[4:0];
            s_nxt.fw_dis = pwdata[9:5];
          end
          else
          begin
            s_nxt.act_chg = pwdata[4:0];
            s_nxt.act_dis = pwdata[9:5];
          end
        end
        A_PREDIS:
        begin
          s_nxt.pdis_init = pwdata[4:0];
          s_nxt.pdis_time = pwdata[15:8];
          s_nxt.pchg_time = pwdata[23:16];
        end
        default: ;
      endcase
      // enabling pwm reloads the adaptive codes and re-arms deep adaptation
      if (paddr == A_CTRL && pwdata[F_PWM_EN] && !s_r.ctrl[F_PWM_EN])
      begin
        s_nxt.pre_code = s_r.act_chg;
        s_nxt.pdis_code = s_r.pdis_init;
        s_nxt.deep = pwdata[F_DEEP];
        s_nxt.miss_cnt = 4'h0;
      end
    end

    // duty evaluation once per period, on the raw synchronised pwm
    s_nxt.pwm_d = pwm_s;
    s_nxt.sw_d = sw_s;
    s_nxt.on_cnt = pwm_s ? inc8(s_r.on_cnt) : 8'h00;
    s_nxt.off_cnt = pwm_s ? 8'h00 : inc8(s_r.off_cnt);
    if (pwm_s && !s_r.pwm_d)
    begin
      s_nxt.high_duty = (s_r.off_cnt < s_r.ccp_act);
    end
    if (!pwm_s && s_r.pwm_d)
    begin
      s_nxt.low_duty = (s_r.on_cnt < s_r.ccp_fw);
      // extreme duty forces load operation; roles are fixed per period
      s_nxt.gen = s_r.ctrl[F_GEN_EN] & gen_s & ~s_nxt.low_duty & ~s_r.high_duty;
    end

    // switching delay measurement from gate command to bridge feedback
    s_nxt.dly_cnt = inc8(s_r.dly_cnt);
    if (s_r.st == S_CHG && !s_r.got_on && sw_s != s_r.sw_d)
    begin
      s_nxt.got_on = 1'b1;
      s_nxt.meas_on = s_r.dly_cnt;
    end
    if (s_r.st == S_DIS && !s_r.got_off && sw_s != s_r.sw_d)
    begin
      s_nxt.got_off = 1'b1;
      s_nxt.meas_off = s_r.dly_cnt;
    end

    // gate sequencer for the active mosfet
    s_nxt.tmr = (s_r.tmr != 8'h00) ? s_r.tmr - 8'h01 : 8'h00;
    case (s_r.st)
      S_OFF:
      begin
        // free-wheel only when duty is normal and pwm is enabled
        s_nxt.fw_on = ~special & s_r.ctrl[F_PWM_EN];
        if (eff_pwm && s_r.ctrl[F_PWM_EN])
        begin
          s_nxt.fw_on = 1'b0;
          s_nxt.tmr = s_r.ccp_fw;
          s_nxt.st = S_WAIT_ON;
        end
      end
      S_WAIT_ON:
      begin
        if (s_r.tmr == 8'h00)
        begin
          s_nxt.dly_cnt = 8'h00;
          s_nxt.got_on = 1'b0;
          if (s_r.ctrl[F_AGC +: 2] == AGC_PLAIN || s_r.ctrl[F_AGC +: 2] == AGC_PDIS)
          begin
            s_nxt.st = S_CHG;
          end
          else
          begin
            s_nxt.tmr = s_r.pchg_time;
            s_nxt.st = S_PRECHG;
          end
        end
      end
      S_PRECHG:
      begin
        act_code = s_r.pre_code;
        // deep mode: second half of precharge runs one step lower
        if (s_r.deep && s_r.tmr <= (s_r.pchg_time >> 1))
        begin
          act_code = step_code(s_r.pre_code, 1'b0);
        end
        if (s_r.tmr == 8'h00)
        begin
          s_nxt.st = S_CHG;
        end
      end
      S_CHG:
      begin
        if (!eff_pwm)
        begin
          s_nxt.tmr = s_r.ccp_fw;
          s_nxt.st = S_SYM;
        end
      end
      S_SYM:
      begin
        if (s_r.tmr == 8'h00)
        begin
          s_nxt.dly_cnt = 8'h00;
          s_nxt.got_off = 1'b0;
          s_nxt.tmr = s_r.ccp_act;
          if (s_r.ctrl[F_AGC +: 2] == AGC_PLAIN)
          begin
            s_nxt.st = S_DIS;
          end
          else
          begin
            s_nxt.st = S_PREDIS;
          end
        end
      end
      S_PREDIS:
      begin
        act_code = adaptive ? s_r.pdis_code : s_r.pdis_init;
        if (adaptive && s_r.deep && s_r.tmr <= (s_r.ccp_act >> 1))
        begin
          act_code = step_code(s_r.pdis_code, 1'b0);
        end
        if ((adaptive ? s_r.pchg_time : s_r.pdis_time) >= s_r.ccp_act - s_r.tmr)
        begin
          s_nxt.st = S_PREDIS;
        end
        else
        begin
          s_nxt.st = S_DIS;
        end
        if (s_r.tmr == 8'h00)
        begin
          s_nxt.st = S_OFF;
        end
      end
      S_DIS:
      begin
        if (s_r.tmr == 8'h00)
        begin
          s_nxt.st = S_OFF;
        end
      end
      default: s_nxt.st = S_OFF;
    endcase
    if (s_r.st == S_CHG)
    begin
      act_code = s_r.act_chg;
    end
    if (s_r.st == S_DIS || s_r.st == S_OFF || s_r.st == S_WAIT_ON || s_r.st == S_SYM)
    begin
      act_code = (s_r.st == S_WAIT_ON) ? s_r.act_chg : s_r.act_dis;
    end

    // adaptation and regulation at each period end; skipped at extreme duty
    if (eff_pwm && s_r.st == S_OFF && s_r.got_on && s_r.got_off && !special)
    begin
      s_nxt.got_on = 1'b0;
      s_nxt.got_off = 1'b0;
      if (adaptive)
      begin
        if (s_r.meas_on != s_r.tgt_on)
        begin
          s_nxt.pre_code = step_code(s_r.pre_code, s_r.meas_on > s_r.tgt_on);
        end
        if (s_r.meas_off != s_r.tgt_off)
        begin
          s_nxt.pdis_code = step_code(s_r.pdis_code, s_r.meas_off > s_r.tgt_off);
        end
        if (s_r.meas_on == s_r.tgt_on && s_r.meas_off == s_r.tgt_off)
        begin
          s_nxt.match_cnt = (s_r.match_cnt == REG_MATCH_N) ? s_r.match_cnt
                                                          : s_r.match_cnt + 4'h1;
        end
        else
        begin
          s_nxt.match_cnt = 4'h0;
        end
        s_nxt.sign_hist = {s_r.sign_hist[REG_WIN-2:0], s_r.meas_on > s_r.tgt_on};
        s_nxt.regulated = (s_nxt.match_cnt == REG_MATCH_N) ||
                          (flips(s_nxt.sign_hist) >= REG_FLIPS);
        // unregulated with a precharge too short to split: single step again
        if (s_r.deep && !s_nxt.regulated && s_r.pchg_time < 8'h02)
        begin
          s_nxt.miss_cnt = s_r.miss_cnt + 4'h1;
          if (s_r.miss_cnt == REG_MATCH_N - 4'h1)
          begin
            s_nxt.deep = 1'b0;
          end
        end
      end
    end
    if (!adaptive)
    begin
      s_nxt.regulated = 1'b0;
      s_nxt.match_cnt = 4'h0;
    end

    // map active and free-wheel roles onto the two gates
    s_nxt.hs = act_is_hs ? (s_nxt.st inside {S_PRECHG, S_CHG, S_SYM}) : s_nxt.fw_on;
    s_nxt.ls = act_is_hs ? s_nxt.fw_on : (s_nxt.st inside {S_PRECHG, S_CHG, S_SYM});
    s_nxt.hcode = act_is_hs ? act_code : (s_nxt.fw_on ? s_r.fw_chg : s_r.fw_dis);
    s_nxt.lcode = act_is_hs ? (s_nxt.fw_on ? s_r.fw_chg : s_r.fw_dis) : act_code;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.ctrl <= RST_CTRL[7:0];
      s_r.ccp_act <= RST_CCP;
      s_r.ccp_fw <= RST_CCP;
      s_r.tgt_on <= RST_TGT;
      s_r.tgt_off <= RST_TGT;
      s_r.pchg_time <= RST_PTIME;
      s_r.pdis_time <= RST_PTIME;
      s_r.st <= S_OFF;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pready = s_r.rdy;
  assign pslverr = s_r.err;
  assign hs_on = s_r.hs;
  assign ls_on = s_r.ls;
  assign hs_code = s_r.hcode;
  assign ls_code = s_r.lcode;

  // assertions
  sequence s_rise;
    eff_pwm && s_r.st == S_OFF && s_r.ctrl[F_PWM_EN];
  endsequence
  property p_no_shoot;
    @(posedge pclk) disable iff (!presetn) !(hs_on && ls_on);
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("both gates on");
  property p_hd_passive;
    @(posedge pclk) disable iff (!presetn) s_r.high_duty && s_r.st == S_OFF |=> !s_r.fw_on;
  endproperty
  a_hd_passive: assert property (p_hd_passive) else $error("fw on at high duty");
  property p_ld_passive;
    @(posedge pclk) disable iff (!presetn) s_r.low_duty && s_r.st == S_OFF |=> !s_r.fw_on;
  endproperty
  a_ld_passive: assert property (p_ld_passive) else $error("fw on at low duty");
  property p_delay_on;
    @(posedge pclk) disable iff (!presetn)
    s_rise and (s_r.ccp_fw == 8'h04) |=> s_r.st == S_WAIT_ON [*5] ##1 s_r.st != S_WAIT_ON;
  endproperty
  a_delay_on: assert property (p_delay_on) else $error("turn-on not delayed");
  property p_plain_skip;
    @(posedge pclk) disable iff (!presetn)
    s_r.ctrl[F_AGC +: 2] == AGC_PLAIN |=> s_r.st != S_PRECHG && s_r.st != S_PREDIS;
  endproperty
  a_plain_skip: assert property (p_plain_skip) else $error("pre phase in mode 00");
  property p_pdis_code;
    @(posedge pclk) disable iff (!presetn)
    s_r.st == S_PREDIS && s_r.ctrl[F_AGC +: 2] == AGC_PDIS && act_is_hs |=>
      hs_code == $past(s_r.pdis_init);
  endproperty
  a_pdis_code: assert property (p_pdis_code) else $error("wrong predischarge code");
  property p_bank0;
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == A_CURRENT && !s_r.ctrl[F_BANK] |=> s_r.act_chg == $past(pwdata[4:0]);
  endproperty
  a_bank0: assert property (p_bank0) else $error("bank 0 write lost");
  property p_bank1;
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == A_CURRENT && s_r.ctrl[F_BANK] |=> s_r.fw_chg == $past(pwdata[4:0]) &&
      $stable(s_r.act_chg);
  endproperty
  a_bank1: assert property (p_bank1) else $error("bank 1 write lost");
  property p_reg_mode;
    @(posedge pclk) disable iff (!presetn) !adaptive |=> !s_r.regulated;
  endproperty
  a_reg_mode: assert property (p_reg_mode) else $error("flag outside adaptive");
  property p_match8;
    @(posedge pclk) disable iff (!presetn)
    adaptive && s_r.match_cnt == REG_MATCH_N |-> s_r.regulated;
  endproperty
  a_match8: assert property (p_match8) else $error("eight matches not flagged");
  property p_no_meas;
    @(posedge pclk) disable iff (!presetn) special && adaptive |=> $stable(s_r.pre_code);
  endproperty
  a_no_meas: assert property (p_no_meas) else $error("adapted at extreme duty");
endmodule

// *** tb/hbpg_bridge.sv ***
// half-bridge model: the switch node follows a gate turn-on after a few cycles
// assumes the sequencer gate outputs and the single pclk domain
`timescale 1ns/1ps
module hbpg_bridge
#(
  parameter int DLY = 3
)(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // gates in, comparator out
  input wire logic hs_on,
  input wire logic ls_on,
  output logic sw
);
  logic [7:0] pipe;
  // any gate change reaches the comparator DLY+1 cycles later, like a real node lag
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pipe <= 8'h00;
      sw <= 1'b0;
    end
    else
    begin
      pipe <= {pipe[6:0], hs_on | ls_on};
      if (pipe[DLY-1] != pipe[DLY])
        sw <= ~sw;
    end
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the gate sequencer: apb tasks and pwm pulse scenarios
// assumes hbpg_core as top and the bridge model on the switch node
`timescale 1ns/1ps
module testbench;
  import hbpg_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pwm_pin = 1'b0;
  logic gen_sense_pin = 1'b0;
  logic [31:0] prdata, q;
  logic pready, pslverr, sw, hs_on, ls_on, e;
  logic [4:0] hs_code, ls_code;
  int error_cnt = 0;
  int comparisons = 0;
  int ls_hi = 0;
  // 20 mhz clock
  always #25 pclk = ~pclk;
  hbpg_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_pin(pwm_pin), .gen_sense_pin(gen_sense_pin),
    .bridge_switched_pin(sw), .hs_on(hs_on), .ls_on(ls_on), .hs_code(hs_code),
    .ls_code(ls_code));
  hbpg_bridge #(.DLY(3)) i_bridge (.pclk(pclk), .presetn(presetn), .hs_on(hs_on),
    .ls_on(ls_on), .sw(sw));
  // free-wheel on-time counter, lets duty scenarios prove the gate stayed off
  always @(posedge pclk)
    if (ls_on === 1'b1)
      ls_hi <= ls_hi + 1;
  task automatic tally_and_finish;
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      error_cnt++;
      $display("Error at %0t: no bus answer", $time);
      tally_and_finish;
    end
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask
  // bounded wait for a gate level; a stuck gate ends the run
  task automatic wait_gate(input logic ls, input logic v);
    int n;
    n = 0;
    while ((ls ? ls_on : hs_on) !== v && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    check(32'(ls ? ls_on : hs_on), 32'(v));
    // a used-up wait is a failure even if the gate arrived on the last edge
    if (n >= 40)
    begin
      error_cnt++;
      tally_and_finish;
    end
  endtask
  task automatic pulse(input int on_c, input int off_c, input int cnt);
    repeat (cnt)
    begin
      pwm_pin <= 1'b1;
      repeat (on_c) @(posedge pclk);
      pwm_pin <= 1'b0;
      repeat (off_c) @(posedge pclk);
    end
  endtask
  // main sequence: registers, bank routing, gate modes, duty extremes
  initial
  begin
    int n;
    int k;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(A_CTRL, RST_CTRL);
    rd(A_TARGET, 32'h0808);
    rd(A_PREDIS, 32'h040400);
    apb(1'b0, 8'h1c, 32'h0);
    check(32'(e), 32'h1);
    check(q, 32'h0);
    apb(1'b1, A_CCP, 32'h0408);
    apb(1'b1, A_CURRENT, 32'h01f);
    apb(1'b1, A_CTRL, 32'h30);
    apb(1'b1, A_CURRENT, 32'h145);
    rd(A_CURRENT, 32'h145);
    apb(1'b1, A_CTRL, 32'ha0);
    rd(A_CURRENT, 32'h01f);
    pwm_pin <= 1'b1;
    wait_gate(1'b1, 1'b0);
    wait_gate(1'b0, 1'b1);
    repeat (4) @(posedge pclk);
    check(32'(hs_code), 32'h1f);
    pwm_pin <= 1'b0;
    wait_gate(1'b0, 1'b0);
    wait_gate(1'b1, 1'b1);
    repeat (4) @(posedge pclk);
    check(32'(ls_code), 32'h05);
    apb(1'b1, A_PREDIS, 32'h04080c);
    apb(1'b1, A_CTRL, 32'ha1);
    pwm_pin <= 1'b1;
    wait_gate(1'b0, 1'b1);
    repeat (4) @(posedge pclk);
    pwm_pin <= 1'b0;
    n = 0;
    repeat (30)
    begin
      @(posedge pclk);
      if (hs_on === 1'b0 && hs_code === 5'h0c)
        n++;
    end
    check(32'(n != 0), 32'h1);
    apb(1'b0, A_MEAS, 32'h0);
    check(32'(q[7:0] != 8'h00), 32'h1);
    apb(1'b0, A_STATUS, 32'h0);
    check(32'(q[0]), 32'h0);
    apb(1'b1, A_CTRL, 32'ha4);
    gen_sense_pin <= 1'b1;
    pulse(30, 30, 3);
    apb(1'b0, A_STATUS, 32'h0);
    check(32'(q[4]), 32'h1);
    gen_sense_pin <= 1'b0;
    apb(1'b1, A_CTRL, 32'ha0);
    pulse(40, 4, 2);
    k = ls_hi;
    pulse(40, 4, 4);
    check(32'(ls_hi - k), 32'h0);
    apb(1'b0, A_STATUS, 32'h0);
    check(32'(q[3]), 32'h1);
    pulse(3, 40, 2);
    k = ls_hi;
    pulse(3, 40, 4);
    check(32'(ls_hi - k), 32'h0);
    apb(1'b0, A_STATUS, 32'h0);
    check(32'(q[2]), 32'h1);
    // adaptive mode: targets far above the bridge lag, so the precharge code must fall
    apb(1'b1, A_CCP, 32'h0410);
    apb(1'b1, A_TARGET, 32'h3030);
    apb(1'b1, A_CTRL, 32'h22);
    apb(1'b1, A_CTRL, 32'ha2);
    pulse(40, 40, 4);
    apb(1'b0, A_STATUS, 32'h0);
    check(32'(q[12:8] < 5'h1f), 32'h1);
    check(32'(q[0]), 32'h0);
    tally_and_finish;
  end
endmodule
